/* File: design/event_router.sv */
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "event_router_params.svh"

module event_router (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // register port
  input wire event_router_pkg::reg_req_type reg_req,
  output var logic [`ER_DATA_W-1:0] read_data,
  // event sources
  input wire logic [`ER_LOCAL_HI:0] local_events,
  input wire logic [`ER_SWAP_W-1:0] soc_events,
  input wire logic [`ER_SWAP_W-1:0] ethernet_port_events,
  input wire logic [`ER_UPPER_W-1:0] upper_events,
  input wire logic emulation_suspend,
  // host interrupt lines
  output var event_router_pkg::host_lines_type host_lines
);
  import event_router_pkg::*;

  logic global_host_enable;
  logic ethernet_port_event_mode;
  logic [`ER_EVENTS-1:0] event_source;
  logic [`ER_EVENTS-1:0] event_sync1;
  logic [`ER_EVENTS-1:0] event_sync2;
  logic [`ER_EVENTS-1:0] event_last;
  logic [`ER_EVENTS-1:0] event_pulse;
  logic [`ER_EVENTS-1:0] raw_pending;
  logic [`ER_EVENTS-1:0] next_raw_pending;
  logic [`ER_EVENTS-1:0] pending_clear;
  logic [`ER_EVENTS-1:0] event_enable;
  logic [`ER_EVENTS-1:0] enabled_pending;
  logic [`ER_HOSTS-1:0] host_enable;
  logic [`ER_HOSTS-1:0] host_retrigger;
  logic [`ER_HOSTS-1:0] next_host_retrigger;
  logic [`ER_CHANNELS-1:0] channel_request;
  logic [`ER_HOSTS-1:0] host_request;
  logic [`ER_HOSTS-1:0] host_active;
  logic [`ER_HOSTS-1:0] next_host_active;
  logic [`ER_DATA_W-1:0] next_read_data;
  logic [`ER_DATA_W-1:0] host_priority [`ER_HOSTS];
  map_type event_channel [`ER_EVENTS];
  map_type channel_host [`ER_CHANNELS];

  // register decode
  logic [`ER_REGION_W-1:0] region;
  logic [`ER_EVT_IDX_W-1:0] entry;
  logic index_is_event;
  logic index_is_host;
  logic [`ER_EVT_IDX_W-1:0] event_index;
  map_type host_index;
  logic write_control;
  logic write_evt_set;
  logic write_evt_clr;
  logic write_host_set;
  logic write_host_clr;
  logic write_pend_clr;
  logic write_evt_map;
  logic write_chan_map;

  assign region = reg_req.addr[`ER_ADDR_W-1:`ER_ADDR_W-`ER_REGION_W];
  assign entry = reg_req.addr[`ER_EVT_IDX_W+`ER_ENTRY_LO-1:`ER_ENTRY_LO];
  assign event_index = reg_req.write_data[`ER_EVT_IDX_W-1:0];
  assign host_index = reg_req.write_data[`ER_MAP_W-1:0];
  // an index with stray upper bits is ignored rather than aliased onto a real entry
  assign index_is_event = (reg_req.write_data[`ER_DATA_W-1:`ER_EVT_IDX_W] == '0);
  assign index_is_host = (reg_req.write_data[`ER_DATA_W-1:`ER_MAP_W] == '0) &&
                         (host_index < map_type'(`ER_HOSTS));
  assign write_control = reg_req.write_strobe && (reg_req.addr == `ER_REG_CONTROL);
  assign write_evt_set = reg_req.write_strobe && (reg_req.addr == `ER_REG_EVT_EN_SET) && index_is_event;
  assign write_evt_clr = reg_req.write_strobe && (reg_req.addr == `ER_REG_EVT_EN_CLR) && index_is_event;
  assign write_host_set = reg_req.write_strobe && (reg_req.addr == `ER_REG_HOST_EN_SET) && index_is_host;
  assign write_host_clr = reg_req.write_strobe && (reg_req.addr == `ER_REG_HOST_EN_CLR) && index_is_host;
  assign write_pend_clr = reg_req.write_strobe && (reg_req.addr == `ER_REG_EVT_PEND_CLR) && index_is_event;
  assign write_evt_map = reg_req.write_strobe && (region == `ER_REGION_EVT_MAP);
  // channel entries past the last channel are refused, not wrapped onto a low channel
  assign write_chan_map = reg_req.write_strobe && (region == `ER_REGION_CHAN_MAP) &&
                          (entry < `ER_EVT_IDX_W'(`ER_CHANNELS));

  // input source selection
  always_comb begin
    event_source[`ER_LOCAL_HI:0] = local_events;
    if (ethernet_port_event_mode) begin
      event_source[`ER_SWAP_HI:`ER_SWAP_LO] = ethernet_port_events;
    end else begin
      event_source[`ER_SWAP_HI:`ER_SWAP_LO] = soc_events;
    end
    // the suspend input splits the upper group: two events below it, five above
    event_source[`ER_SUSPEND_EVENT-1:`ER_SWAP_HI+1] = upper_events[`ER_LOW_UPPER_W-1:0];
    event_source[`ER_SUSPEND_EVENT] = emulation_suspend;
    event_source[`ER_EVENTS-1:`ER_SUSPEND_EVENT+1] = upper_events[`ER_UPPER_W-1:`ER_LOW_UPPER_W];
  end

  // two-stage synchroniser then rising-edge detect; a held level counts once
  // the extra latency is traded for safety against sources from slower domains
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      event_sync1 <= '0;
      event_sync2 <= '0;
      event_last <= '0;
    end else begin
      event_sync1 <= event_source;
      event_sync2 <= event_sync1;
      event_last <= event_sync2;
    end
  end

  assign event_pulse = event_sync2 & ~event_last;

  // pending capture; a new pulse wins over a clear in the same cycle
  always_comb begin
    pending_clear = '0;
    if (write_pend_clr) begin
      pending_clear[event_index] = 1'b1;
    end
    next_raw_pending = (raw_pending & ~pending_clear) | event_pulse;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      raw_pending <= '0;
    end else begin
      raw_pending <= next_raw_pending;
    end
  end

  // per-event enables
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      event_enable <= '0;
    end else if (write_evt_set) begin
      event_enable[event_index] <= 1'b1;
    end else if (write_evt_clr) begin
      event_enable[event_index] <= 1'b0;
    end
  end

  // disabled events still show in raw status; only the enabled view is gated
  assign enabled_pending = raw_pending & event_enable;

  // control bits
  // a mode change keeps pending state, so a swapped source may leave one stray edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      global_host_enable <= 1'b0;
      ethernet_port_event_mode <= 1'b0;
    end else if (write_control) begin
      global_host_enable <= reg_req.write_data[`ER_CTRL_GLOBAL_BIT];
      ethernet_port_event_mode <= reg_req.write_data[`ER_CTRL_MODE_BIT];
    end
  end

  // mapping tables; out-of-range codes leave the entry effectively unmapped
  // reset parks every event on channel 0 and routes channel c to host c
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int e = 0; e < `ER_EVENTS; e++) begin
        event_channel[e] <= `ER_RESET_EVT_MAP;
      end
    end else if (write_evt_map) begin
      event_channel[entry] <= reg_req.write_data[`ER_MAP_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int c = 0; c < `ER_CHANNELS; c++) begin
        channel_host[c] <= map_type'(c);
      end
    end else if (write_chan_map) begin
      channel_host[entry[`ER_MAP_W-1:0]] <= reg_req.write_data[`ER_MAP_W-1:0];
    end
  end

  // channel and host requests
  // a flat compare per event; the tables are too small to justify a decoder tree
  always_comb begin
    channel_request = '0;
    for (int e = 0; e < `ER_EVENTS; e++) begin
      for (int c = 0; c < `ER_CHANNELS; c++) begin
        if (enabled_pending[e] && event_channel[e] == map_type'(c)) begin
          channel_request[c] = 1'b1;
        end
      end
    end
  end

  // host codes of ten and above match no host, which parks the channel
  always_comb begin
    host_request = '0;
    for (int c = 0; c < `ER_CHANNELS; c++) begin
      for (int h = 0; h < `ER_HOSTS; h++) begin
        if (channel_request[c] && channel_host[c] == map_type'(h)) begin
          host_request[h] = 1'b1;
        end
      end
    end
  end

  // priority: lowest channel first, then lowest event inside it
  // only software sees the ranking; the lines themselves stay plain ORs
  always_comb begin
    logic found;
    found = 1'b0;
    for (int h = 0; h < `ER_HOSTS; h++) begin
      host_priority[h] = '0;
      host_priority[h][`ER_PRIO_NONE_BIT] = 1'b1;
      found = 1'b0;
      for (int c = 0; c < `ER_CHANNELS; c++) begin
        if (!found && channel_request[c] && channel_host[c] == map_type'(h)) begin
          found = 1'b1;
          host_priority[h][`ER_PRIO_NONE_BIT] = 1'b0;
          host_priority[h][`ER_PRIO_CHAN_LO+`ER_MAP_W-1:`ER_PRIO_CHAN_LO] = map_type'(c);
          for (int e = `ER_EVENTS - 1; e >= 0; e--) begin
            if (enabled_pending[e] && event_channel[e] == map_type'(c)) begin
              host_priority[h][`ER_EVT_IDX_W-1:0] = `ER_EVT_IDX_W'(e);
            end
          end
        end
      end
    end
  end

  // host enables; setting an already enabled host drops its line for one cycle
  always_comb begin
    next_host_retrigger = '0;
    if (write_host_set && host_enable[host_index]) begin
      next_host_retrigger[host_index] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      host_enable <= '0;
    end else if (write_host_set) begin
      host_enable[host_index] <= 1'b1;
    end else if (write_host_clr) begin
      host_enable[host_index] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      host_retrigger <= '0;
    end else begin
      host_retrigger <= next_host_retrigger;
    end
  end

  // global enable gates but never replaces the per-host enables
  assign next_host_active = host_request & host_enable & ~host_retrigger &
                            {`ER_HOSTS{global_host_enable}};

  // twin of the driven lines for the readback register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      host_active <= '0;
    end else begin
      host_active <= next_host_active;
    end
  end

  // output lines, kept in flops so the cores see both copies on the same edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      host_lines <= '0;
    end else begin
      host_lines.core0_status <= next_host_active[`ER_CORE_HOSTS-1:0];
      host_lines.core1_status <= next_host_active[`ER_CORE_HOSTS-1:0];
      host_lines.exported <= next_host_active[`ER_HOSTS-1:`ER_EXPORT_LO];
    end
  end

  // read path, answered in the cycle after the strobe
  // gating by the strobe keeps read_data at zero between answers
  always_comb begin
    next_read_data = `ER_RESET_WORD;
    if (region == `ER_REGION_EVT_MAP) begin
      next_read_data[`ER_MAP_W-1:0] = event_channel[entry];
    end else if (region == `ER_REGION_CHAN_MAP) begin
      if (entry < `ER_EVT_IDX_W'(`ER_CHANNELS)) begin
        next_read_data[`ER_MAP_W-1:0] = channel_host[entry[`ER_MAP_W-1:0]];
      end
    end else if (region == `ER_REGION_PRIORITY) begin
      if (entry < `ER_EVT_IDX_W'(`ER_HOSTS)) begin
        next_read_data = host_priority[entry[`ER_MAP_W-1:0]];
      end
    end else begin
      unique case (reg_req.addr)
        `ER_REG_CONTROL: begin
          next_read_data[`ER_CTRL_GLOBAL_BIT] = global_host_enable;
          next_read_data[`ER_CTRL_MODE_BIT] = ethernet_port_event_mode;
        end
        `ER_REG_RAW_LO: next_read_data = raw_pending[`ER_DATA_W-1:0];
        `ER_REG_RAW_HI: next_read_data = raw_pending[`ER_EVENTS-1:`ER_DATA_W];
        `ER_REG_ENABLED_LO: next_read_data = enabled_pending[`ER_DATA_W-1:0];
        `ER_REG_ENABLED_HI: next_read_data = enabled_pending[`ER_EVENTS-1:`ER_DATA_W];
        `ER_REG_EVT_EN_LO: next_read_data = event_enable[`ER_DATA_W-1:0];
        `ER_REG_EVT_EN_HI: next_read_data = event_enable[`ER_EVENTS-1:`ER_DATA_W];
        `ER_REG_HOST_EN: next_read_data[`ER_HOSTS-1:0] = host_enable;
        `ER_REG_HOST_LINES: next_read_data[`ER_HOSTS-1:0] = host_active;
        default: next_read_data = `ER_RESET_WORD;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      read_data <= `ER_RESET_WORD;
    end else if (reg_req.read_strobe) begin
      read_data <= next_read_data;
    end else begin
      read_data <= `ER_RESET_WORD;
    end
  end

endmodule
`default_nettype wire

/* File: design/event_router_params.svh */
`ifndef EVENT_ROUTER_PARAMS_SVH
`define EVENT_ROUTER_PARAMS_SVH

// sizes
`define ER_EVENTS 64
`define ER_CHANNELS 10
`define ER_HOSTS 10
`define ER_ADDR_W 12
`define ER_DATA_W 32
`define ER_MAP_W 4
`define ER_EVT_IDX_W 6

// event input layout
`define ER_LOCAL_HI 31
`define ER_SWAP_LO 32
`define ER_SWAP_HI 55
`define ER_SWAP_W 24
`define ER_UPPER_W 7
`define ER_SUSPEND_EVENT 58
`define ER_LOW_UPPER_W 2

// host output layout
`define ER_CORE_HOSTS 2
`define ER_EXPORT_LO 2
`define ER_EXPORT_W 8

// control register fields
`define ER_CTRL_GLOBAL_BIT 0
`define ER_CTRL_MODE_BIT 1

// register offsets (byte addresses)
`define ER_REG_CONTROL 12'h000
`define ER_REG_EVT_EN_SET 12'h004
`define ER_REG_EVT_EN_CLR 12'h008
`define ER_REG_HOST_EN_SET 12'h00C
`define ER_REG_HOST_EN_CLR 12'h010
`define ER_REG_EVT_PEND_CLR 12'h014
`define ER_REG_RAW_LO 12'h018
`define ER_REG_RAW_HI 12'h01C
`define ER_REG_ENABLED_LO 12'h020
`define ER_REG_ENABLED_HI 12'h024
`define ER_REG_EVT_EN_LO 12'h028
`define ER_REG_EVT_EN_HI 12'h02C
`define ER_REG_HOST_EN 12'h030
`define ER_REG_HOST_LINES 12'h034

// table regions: addr[11:8] selects, addr[7:2] is the entry
`define ER_REGION_W 4
`define ER_ENTRY_LO 2
`define ER_REGION_EVT_MAP 4'h1
`define ER_REGION_CHAN_MAP 4'h2
`define ER_REGION_PRIORITY 4'h3

// priority word fields
`define ER_PRIO_NONE_BIT 31
`define ER_PRIO_CHAN_LO 16

// reset values
`define ER_RESET_WORD 32'h0000_0000
`define ER_RESET_EVT_MAP 4'h0

`endif

/* File: design/event_router_pkg.sv */
`include "event_router_params.svh"

package event_router_pkg;

  typedef struct packed {
    logic [`ER_ADDR_W-1:0] addr;
    logic [`ER_DATA_W-1:0] write_data;
    logic write_strobe;
    logic read_strobe;
  } reg_req_type;

  typedef struct packed {
    logic [`ER_CORE_HOSTS-1:0] core0_status;
    logic [`ER_CORE_HOSTS-1:0] core1_status;
    logic [`ER_EXPORT_W-1:0] exported;
  } host_lines_type;

  typedef logic [`ER_MAP_W-1:0] map_type;

endpackage

/* File: tb/event_router_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module event_router_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // watched ports
  input wire event_router_pkg::reg_req_type reg_req,
  input wire logic [31:0] read_data,
  input wire event_router_pkg::host_lines_type host_lines
);
  import event_router_pkg::*;
  logic [9:0] hv;
  logic [3:0] wi;
  logic wc;
  logic rc;
  logic hset;
  logic hclr;
  assign hv = {host_lines.exported, host_lines.core0_status};
  assign wi = reg_req.write_data[3:0];
  assign wc = reg_req.write_strobe && reg_req.addr == 12'h000;
  assign rc = reg_req.read_strobe && reg_req.addr == 12'h000;
  assign hset = reg_req.write_strobe && reg_req.addr == 12'h00C && reg_req.write_data < 32'h0000_000A;
  assign hclr = reg_req.write_strobe && reg_req.addr == 12'h010 && reg_req.write_data < 32'h0000_000A;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_glob_off;
    wc && !reg_req.write_data[0] ##1 !wc;
  endsequence
  sequence s_echo;
    wc ##1 !reg_req.write_strobe ##1 rc;
  endsequence
  a_read_idle: assert property (!$past(reg_req.read_strobe) |-> read_data == 32'h0000_0000)
    else $error("read data outside answer");
  a_unmapped_read: assert property (reg_req.read_strobe && reg_req.addr inside {[12'h038:12'h0FC]}
    |=> read_data == 32'h0000_0000) else $error("unmapped read not zero");
  a_reset_clear: assert property ($rose(reset_n) |-> host_lines == '0)
    else $error("lines not cleared by reset");
  a_cores_match: assert property (host_lines.core0_status == host_lines.core1_status)
    else $error("core status bits differ");
  a_ctrl_echo: assert property (s_echo |=> read_data[1:0] == $past(reg_req.write_data[1:0], 3))
    else $error("control bits not read back");
  a_glob_off: assert property (s_glob_off |=> hv == 10'h000)
    else $error("line high with global enable off");
  a_host_clr: assert property (hclr ##1 !hset |=> !hv[$past(wi, 2)])
    else $error("disabled host line high");
  // the low pulse may land two or three cycles after the set write, never earlier
  a_retrig_low: assert property (hset && hv[wi] |-> ##2 (!hv[$past(wi, 2)] or ##1 !hv[$past(wi, 3)]))
    else $error("no low pulse on retrigger");
endmodule
`default_nettype wire

/* File: tb/event_source.sv */
`timescale 1ns/1ps
`default_nettype none
module event_source (
  // clock and commands
  input wire logic clk,
  input wire logic mode,
  input wire logic [63:0] ev,
  // event lines toward the router
  output logic [31:0] local_events,
  output logic [23:0] soc_events,
  output logic [23:0] ethernet_port_events,
  output logic [6:0] upper_events,
  output logic emulation_suspend
);
  logic [23:0] junk;
  initial junk = 24'h5A_5A5A;
  // the unselected source keeps running, so a leak from it shows up
  always @(posedge clk) junk <= ~junk;
  assign local_events = ev[31:0];
  assign soc_events = mode ? junk : ev[55:32];
  assign ethernet_port_events = mode ? ev[55:32] : junk;
  assign upper_events = {ev[63:59], ev[57:56]};
  assign emulation_suspend = ev[58];
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import event_router_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic mode = 1'b0;
  logic [63:0] ev = '0;
  logic [63:0] p;
  logic [31:0] loc;
  logic [23:0] soc;
  logic [23:0] eth;
  logic [6:0] upp;
  logic sus;
  logic [31:0] read_data;
  reg_req_type req = '0;
  host_lines_type hl;
  wire [9:0] hv = {hl.exported, hl.core0_status};
  int bad_count = 0;
  int n_tests = 0;
  int chm[64];
  int hm[10];
  bit raw[64];
  bit en[64];
  bit hen[10];
  bit glob;
  int k;
  always #25 clk = ~clk;
  event_source u_src (.clk(clk), .mode(mode), .ev(ev), .local_events(loc), .soc_events(soc),
    .ethernet_port_events(eth), .upper_events(upp), .emulation_suspend(sus));
  event_router u_dut (.clk(clk), .reset_n(reset_n), .reg_req(req), .read_data(read_data),
    .local_events(loc), .soc_events(soc), .ethernet_port_events(eth), .upper_events(upp),
    .emulation_suspend(sus), .host_lines(hl));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input int v);
    req.addr <= a;
    req.write_data <= 32'(v);
    req.write_strobe <= 1'b1;
    @(posedge clk);
    req.write_strobe <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    req.addr <= a;
    req.read_strobe <= 1'b1;
    @(posedge clk);
    req.read_strobe <= 1'b0;
    #1 d = read_data;
    @(posedge clk);
    chk(64'(d), 64'(v));
  endtask
  function automatic logic [9:0] lines();
    logic [9:0] l = '0;
    for (int e = 0; e < 64; e++) begin
      if (raw[e] && en[e] && glob && hen[hm[chm[e]]]) l[hm[chm[e]]] = 1'b1;
    end
    return l;
  endfunction
  // lowest channel first, then lowest event inside it
  function automatic logic [31:0] prio(int h);
    for (int c = 0; c < 10; c++) begin
      for (int e = 0; e < 64; e++) begin
        if (hm[c] == h && chm[e] == c && raw[e] && en[e]) return {12'h000, 4'(c), 10'h000, 6'(e)};
      end
    end
    return 32'h8000_0000;
  endfunction
  task automatic look();
    @(negedge clk);
    chk(64'(hv), 64'(lines()));
    chk(64'(hl.core1_status), 64'(lines() & 10'h003));
    @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #1_000_000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    void'($urandom(44));
    for (int e = 0; e < 64; e++) chm[e] = 0;
    for (int c = 0; c < 10; c++) hm[c] = c;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(12'h000, 32'h0000_0000);
    rd(12'h21C, 32'h0000_0007);
    wr(12'h038, -1);
    rd(12'h038, 32'h0000_0000);
    wr(12'h00C, 10);
    wr(12'h004, 64);
    wr(12'h200, 10);
    wr(12'h228, 3);
    rd(12'h030, 32'h0000_0000);
    rd(12'h02C, 32'h0000_0000);
    rd(12'h200, 32'h0000_000A);
    rd(12'h228, 32'h0000_0000);
    $display("test reset and refusals done");
    for (int r = 0; r < 6; r++) begin
      for (int e = 0; e < 64; e++) begin
        chm[e] = $urandom % 10;
        wr(12'h100 + 12'(4 * e), chm[e]);
        en[e] = 1'($urandom);
        wr(en[e] ? 12'h004 : 12'h008, e);
      end
      for (int c = 0; c < 10; c++) begin
        hm[c] = (r == 0) ? c : $urandom % 10;
        wr(12'h200 + 12'(4 * c), hm[c]);
        hen[c] = ($urandom % 4) != 0;
        wr(hen[c] ? 12'h00C : 12'h010, c);
      end
      glob = 1'b1;
      mode <= r[0];
      wr(12'h000, 1 + 2 * r[0]);
      rd(12'h000, 32'(1 + 2 * r[0]));
      // a source swap may leave a stray edge in the synchroniser
      repeat (8) @(posedge clk);
      for (int e = 0; e < 64; e++) begin
        wr(12'h014, e);
        raw[e] = 1'b0;
      end
      ev <= {$urandom, $urandom};
      @(posedge clk);
      for (int e = 0; e < 64; e++) raw[e] = ev[e];
      ev <= '0;
      repeat (5) @(posedge clk);
      look();
      for (int e = 0; e < 64; e++) p[e] = raw[e];
      rd(12'h018, p[31:0]);
      rd(12'h01C, p[63:32]);
      for (int e = 0; e < 64; e++) p[e] = raw[e] && en[e];
      rd(12'h020, p[31:0]);
      rd(12'h024, p[63:32]);
      for (int e = 0; e < 64; e++) p[e] = en[e];
      rd(12'h028, p[31:0]);
      rd(12'h02C, p[63:32]);
      p = '0;
      for (int c = 0; c < 10; c++) p[c] = hen[c];
      rd(12'h030, p[31:0]);
      p = 64'(lines());
      rd(12'h034, p[31:0]);
      rd(12'h100 + 12'(4 * r), chm[r]);
      for (int h = 0; h < 10; h++) begin
        if (hen[h]) rd(12'h300 + 12'(4 * h), prio(h));
      end
      p = 64'(lines());
      k = -1;
      for (int h = 9; h >= 0; h--) begin
        if (p[h]) k = h;
      end
      if (k >= 0) begin
        wr(12'h00C, k);
        @(negedge clk);
        chk(64'(hv[k]), 64'(0));
      end
      repeat (3) @(posedge clk);
      look();
      if (k >= 0) begin
        hen[k] = 1'b0;
        wr(12'h010, k);
        look();
      end
      glob = 1'b0;
      wr(12'h000, 2 * r[0]);
      look();
      $display("test round %0d done", r);
    end
    // a reset in mid-run must clear pending state and restore the default maps
    reset_n <= 1'b0;
    mode <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int e = 0; e < 64; e++) raw[e] = 1'b0;
    look();
    rd(12'h000, 32'h0000_0000);
    rd(12'h018, 32'h0000_0000);
    rd(12'h01C, 32'h0000_0000);
    rd(12'h21C, 32'h0000_0007);
    $display("test mid-run reset done");
    conclude();
  end
endmodule
bind event_router event_router_assertions u_chk (.clk(clk), .reset_n(reset_n), .reg_req(reg_req),
  .read_data(read_data), .host_lines(host_lines));
`default_nettype wire
